// File: hw/ppm_defs.vh
// Constants for the push-pull protection and mode controller.
// Assumes a 125 MHz reference clock; included by the controller file.
`ifndef PPM_DEFS_VH
`define PPM_DEFS_VH

// Reference clock period
`define PPM_CLK_NS        8

// Counts are sized to their counters (16-bit, 3-bit for sync edges) so nothing is truncated
// Overvoltage stop response, 550 ns rounded up to 69 cycles
`define PPM_OV_DELAY_NS   550
`define PPM_OV_DELAY_CYC  16'h0045

// Soft-short hiccup off time, 100 ns rounded up to 13 cycles
`define PPM_HICCUP_NS     100
`define PPM_HICCUP_CYC    16'h000D

// Hard-short trigger response, 65 ns rounded up to 9 cycles
`define PPM_HARD_RESP_NS  65
`define PPM_HARD_RESP_CYC 16'h0009

// Hard-short persistence limit, 200 us is 25000 cycles
`define PPM_HARD_LONG_US  200
`define PPM_HARD_LONG_CYC 16'h61A8

// Enable glitch filter, 5 us is 625 cycles
`define PPM_EN_FILT_NS    5000
`define PPM_EN_FILT_CYC   16'h0271

// Break-before-make dead time, 70 ns rounded up to 9 cycles
`define PPM_DEAD_NS       70
`define PPM_DEAD_CYC      16'h0009

// External clock loss timeout, in cycles (plain default of 1250)
`define PPM_SYNC_LOSS_CYC 16'h04E2

// Internal oscillator half period, 62 cycles (about 1 MHz oscillator)
`define PPM_OSC_HALF_CYC  16'h003E

// External clock edges counted before taking sync mode
`define PPM_SYNC_DET_EDGES 3'h5

// Number of synchronised input flags
`define PPM_NFLAG         13

`endif

// File: hw/ppm_ctrl.v
// Protection and mode control for a push-pull transformer driver.
// Assumes analog comparators deliver clean threshold flags on pins;
// every flag is resynchronised to i_ref_clk before use.
`timescale 1ns/1ns
`include "ppm_defs.vh"

// Summary of operation
// - Supply above overvoltage rising level stops switching after 550 ns.
// - Overvoltage stop holds until supply falls below the falling level.
// - Cycle-by-cycle overcurrent on both switches, off during soft-start.
// - Soft short: each trip turns both switches off 100 ns, then retries.
// - Deep soft-start dip means hard short, 5 A trip, 65 ns response.
// - Hard short over 200 us discharges soft-start, then restarts it.
// - Switching needs enable above its level and supply above lockout.
// - Enable pulses shorter than 5 us change nothing.
// - Floating enable is pulled low, keeping shutdown.
// - Thermal trip above 180 C stops switching until below 147 C.
// - Soft-start launches at power-up and every enable rising edge.
// - Operation mode only after enable, supply and soft-start done.
// - Disabled or supply below 2.8 V: both drain outputs high impedance.
// - Sync mode divides the external clock by two for the drives.
// - Falls back to internal clock after the sync-loss timeout.
// - Five external clock cycles are detected before entering sync.
// - Sync mode disables duty control and spread modulation.
// - About 70 ns dead time between the two alternating drives.
// - Floating external clock pin halts switching.
module ppm_ctrl #(
  parameter [15:0] HARD_LONG_CYC = `PPM_HARD_LONG_CYC,
  parameter [15:0] EN_FILT_CYC   = `PPM_EN_FILT_CYC,
  parameter [15:0] SYNC_LOSS_CYC = `PPM_SYNC_LOSS_CYC,
  parameter [15:0] OSC_HALF_CYC  = `PPM_OSC_HALF_CYC
) (
  input  wire i_ref_clk,
  input  wire i_rst,
  input  wire i_enable_threshold_pin,
  input  wire i_supply_lockout_ok,
  input  wire i_ov_above_rise,
  input  wire i_ov_above_fall,
  input  wire i_temp_above_trip,
  input  wire i_temp_above_release,
  input  wire i_overcurrent_trip,
  input  wire i_hard_trip,
  input  wire i_softstart_dip_deep,
  input  wire i_softstart_done,
  input  wire i_softstart_empty,
  input  wire i_ext_clk,
  input  wire i_ext_clk_floating,
  output reg  o_drain_out_a,
  output reg  o_drain_out_b,
  output reg  o_drain_out_a_oe,
  output reg  o_drain_out_b_oe,
  output reg  o_softstart_run,
  output reg  o_softstart_discharge,
  output wire o_enable_pulldown,
  output reg  o_duty_control_en,
  output reg  o_spread_modulation_en,
  output reg  o_sync_mode,
  output reg  o_operating,
  output reg  o_overvoltage_guard,
  output reg  o_thermal_trip,
  output reg  o_hard_short
);

  localparam [3:0] ST_OFF   = 4'h1;
  localparam [3:0] ST_SOFT  = 4'h2;
  localparam [3:0] ST_RUN   = 4'h4;
  localparam [3:0] ST_DISCH = 4'h8;

  localparam [15:0] OV_DELAY  = `PPM_OV_DELAY_CYC;
  localparam [15:0] HICCUP    = `PPM_HICCUP_CYC;
  localparam [15:0] HARD_RESP = `PPM_HARD_RESP_CYC;
  localparam [15:0] DEAD      = `PPM_DEAD_CYC;
  localparam [2:0]  DET_EDGES = `PPM_SYNC_DET_EDGES;
  localparam        NF        = `PPM_NFLAG;

  wire [NF-1:0] raw;
  reg  [NF-1:0] sync_a;
  reg  [NF-1:0] sync_b;

  // Floating enable reads low through this weak pull-down
  // pull-down always on
  assign o_enable_pulldown = 1'b1;

  assign raw = {i_ext_clk_floating, i_ext_clk, i_softstart_empty,
                i_softstart_done, i_softstart_dip_deep, i_hard_trip,
                i_overcurrent_trip, i_temp_above_release,
                i_temp_above_trip, i_ov_above_fall, i_ov_above_rise,
                i_supply_lockout_ok, i_enable_threshold_pin};

  // Two-stage synchroniser per input flag
  genvar g;
  generate
    for (g = 0; g < NF; g = g + 1)
    begin : g_sync
      always @(posedge i_ref_clk)
      begin
        if (i_rst)
        begin
          sync_a[g] <= 1'b0;
          sync_b[g] <= 1'b0;
        end
        else
        begin
          sync_a[g] <= raw[g];
          sync_b[g] <= sync_a[g];
        end
      end
    end
  endgenerate

  wire en_raw    = sync_b[0];
  wire sup_ok    = sync_b[1];
  wire ov_rise   = sync_b[2];
  wire ov_fall   = sync_b[3];
  wire t_trip    = sync_b[4];
  wire t_rel     = sync_b[5];
  wire oc_trip   = sync_b[6];
  wire hard_trip = sync_b[7];
  wire dip_deep  = sync_b[8];
  wire ss_done   = sync_b[9];
  wire ss_empty  = sync_b[10];
  wire ext_clk   = sync_b[11];
  wire clk_float = sync_b[12];

  reg [3:0]  state;
  reg [3:0]  next_state;
  reg        en_filt;
  reg [15:0] en_cnt;
  reg [15:0] ov_cnt;
  reg [15:0] hic_cnt;
  reg [15:0] hard_cnt;
  reg [15:0] long_cnt;
  reg [15:0] gap_cnt;
  reg [15:0] osc_cnt;
  reg [15:0] dead_cnt;
  reg [2:0]  det_cnt;
  reg        ext_prev;
  reg        phase;

  wire ext_edge = ext_clk & ~ext_prev;
  wire hard_cond = dip_deep & hard_trip;
  wire long_hit = (long_cnt >= HARD_LONG_CYC);
  wire osc_tick = (osc_cnt == OSC_HALF_CYC - 16'h0001);
  wire tick = o_sync_mode ? ext_edge : osc_tick;
  wire active = (state == ST_SOFT) | (state == ST_RUN);

  wire permit = active & sup_ok & en_filt & ~o_overvoltage_guard &
                ~o_thermal_trip & ~o_hard_short & ~clk_float;

  // Enable glitch filter: change only after a stable differing level
  // 5 us enable filter
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      en_filt <= 1'b0;
      en_cnt  <= 16'h0000;
    end
    else if (en_raw == en_filt)
      en_cnt <= 16'h0000;
    else if (en_cnt >= EN_FILT_CYC - 16'h0001)
    begin
      en_filt <= en_raw;
      en_cnt  <= 16'h0000;
    end
    else
      en_cnt <= en_cnt + 16'h0001;
  end

  // Overvoltage stop with delayed set and hysteretic release
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      ov_cnt              <= 16'h0000;
      o_overvoltage_guard <= 1'b0;
    end
    else
    begin
      ov_cnt <= ov_rise ? ((ov_cnt < OV_DELAY) ? ov_cnt + 16'h0001
                                                : ov_cnt)
                        : 16'h0000;
      if (ov_rise && ov_cnt >= OV_DELAY - 16'h0001)
        o_overvoltage_guard <= 1'b1;
      else if (!ov_fall)
        o_overvoltage_guard <= 1'b0;
    end
  end

  // Thermal trip latch, set wins over release
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
      o_thermal_trip <= 1'b0;
    else if (t_trip)
      o_thermal_trip <= 1'b1;
    else if (!t_rel)
      o_thermal_trip <= 1'b0;
  end

  // Hard-short detection and persistence timing
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      hard_cnt     <= 16'h0000;
      long_cnt     <= 16'h0000;
      o_hard_short <= 1'b0;
    end
    else
    begin
      hard_cnt <= hard_cond ? ((hard_cnt < HARD_RESP)
                               ? hard_cnt + 16'h0001 : hard_cnt)
                            : 16'h0000;
      o_hard_short <= hard_cond & (hard_cnt >= HARD_RESP - 16'h0001);
      if (!o_hard_short)
        long_cnt <= 16'h0000;
      else if (!long_hit)
        long_cnt <= long_cnt + 16'h0001;
    end
  end

  // Soft-short hiccup: off window retriggered by each trip in ST_RUN without a deep dip
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
      hic_cnt <= 16'h0000;
    else if (oc_trip && !dip_deep && state == ST_RUN)
      hic_cnt <= HICCUP;
    else if (hic_cnt != 16'h0000)
      hic_cnt <= hic_cnt - 16'h0001;
  end

  // External clock detection, loss timeout and mode choice
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      ext_prev    <= 1'b0;
      det_cnt     <= 3'h0;
      gap_cnt     <= 16'h0000;
      o_sync_mode <= 1'b0;
    end
    else
    begin
      ext_prev <= ext_clk;
      if (ext_edge)
      begin
        gap_cnt <= 16'h0000;
        if (!o_sync_mode && det_cnt == DET_EDGES - 3'h1)
          o_sync_mode <= 1'b1;
        else if (!o_sync_mode)
          det_cnt <= det_cnt + 3'h1;
      end
      else if (gap_cnt >= SYNC_LOSS_CYC - 16'h0001)
      begin
        o_sync_mode <= 1'b0;
        det_cnt     <= 3'h0;
      end
      else
        gap_cnt <= gap_cnt + 16'h0001;
    end
  end

  // Internal oscillator and phase toggle with dead time
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      osc_cnt  <= 16'h0000;
      phase    <= 1'b0;
      dead_cnt <= DEAD;
    end
    else
    begin
      osc_cnt <= osc_tick ? 16'h0000 : osc_cnt + 16'h0001;
      if (tick)
      begin
        phase    <= ~phase;
        dead_cnt <= DEAD;
      end
      else if (dead_cnt != 16'h0000)
        dead_cnt <= dead_cnt - 16'h0001;
    end
  end

  // Mode sequencing
  always @*
  begin
    next_state = state;
    case (state)
      ST_OFF:
        if (en_filt && sup_ok)
          next_state = ST_SOFT;
      ST_SOFT:
        if (!en_filt || !sup_ok)
          next_state = ST_OFF;
        else if (long_hit)
          next_state = ST_DISCH;
        else if (ss_done)
          next_state = ST_RUN;
      ST_RUN:
        if (!en_filt || !sup_ok)
          next_state = ST_OFF;
        else if (long_hit)
          next_state = ST_DISCH;
      ST_DISCH:
        if (!en_filt || !sup_ok)
          next_state = ST_OFF;
        else if (ss_empty && !hard_cond)
          next_state = ST_SOFT;
      default:
        next_state = ST_OFF;
    endcase
  end

  // State register and registered outputs
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      state                  <= ST_OFF;
      o_drain_out_a          <= 1'b0;
      o_drain_out_b          <= 1'b0;
      o_drain_out_a_oe       <= 1'b0;
      o_drain_out_b_oe       <= 1'b0;
      o_softstart_run        <= 1'b0;
      o_softstart_discharge  <= 1'b0;
      o_duty_control_en      <= 1'b1;
      o_spread_modulation_en <= 1'b1;
      o_operating            <= 1'b0;
    end
    else
    begin
      state <= next_state;
      o_drain_out_a <= permit & (hic_cnt == 16'h0000) &
                       (dead_cnt == 16'h0000) & ~phase;
      o_drain_out_b <= permit & (hic_cnt == 16'h0000) &
                       (dead_cnt == 16'h0000) & phase;
      o_drain_out_a_oe <= (state != ST_OFF) & en_filt & sup_ok;
      o_drain_out_b_oe <= (state != ST_OFF) & en_filt & sup_ok;
      o_softstart_run <= (state == ST_SOFT);
      o_softstart_discharge <= (state == ST_DISCH);
      // no duty or spread in sync
      o_duty_control_en      <= ~o_sync_mode;
      o_spread_modulation_en <= ~o_sync_mode;
      o_operating <= (state == ST_RUN);
    end
  end

endmodule

// File: test/ppm_ctrl_properties.sv
// Port assertions for the protection and mode controller.
// Bound to every ppm_ctrl instance at the foot of this file.
`timescale 1ns/1ns
module ppm_ctrl_props #(
  parameter [15:0] HARD_LONG_CYC = 16'h61A8,
  parameter [15:0] SYNC_LOSS_CYC = 16'h04E2
) (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_supply_lockout_ok,
  input wire i_ov_above_rise,
  input wire i_hard_trip,
  input wire i_softstart_dip_deep,
  input wire i_softstart_done,
  input wire i_ext_clk,
  input wire o_drain_out_a,
  input wire o_drain_out_b,
  input wire o_drain_out_a_oe,
  input wire o_softstart_discharge,
  input wire o_duty_control_en,
  input wire o_sync_mode,
  input wire o_operating,
  input wire o_overvoltage_guard,
  input wire o_thermal_trip,
  input wire o_hard_short
);
  reg [15:0] idle_cnt;
  reg        ext_d;

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  // Cycles since the last external clock rise
  always @(posedge i_ref_clk)
  begin
    ext_d <= i_ext_clk;
    if (i_rst || (i_ext_clk && !ext_d))
      idle_cnt <= 16'h0000;
    else if (idle_cnt != 16'hFFFF)
      idle_cnt <= idle_cnt + 16'h0001;
  end

  no_overlap_a:
    assert property (!(o_drain_out_a && o_drain_out_b))
    else $error("drives overlap");
  dead_gap_a:
    assert property ($fell(o_drain_out_a) |-> !o_drain_out_b [*8])
    else $error("dead time too short");
  dead_gap_ba_a:
    assert property ($fell(o_drain_out_b) |-> !o_drain_out_a [*8])
    else $error("dead time too short after b");
  fault_off_a:
    assert property ((o_overvoltage_guard || o_thermal_trip ||
      o_hard_short) [*3] |-> !o_drain_out_a && !o_drain_out_b)
    else $error("drive during fault");
  ov_late_a:
    assert property ($rose(o_overvoltage_guard) |->
      $past(i_ov_above_rise, 60))
    else $error("overvoltage stop too early");
  hiz_off_a:
    assert property (!i_supply_lockout_ok [*5] |-> !o_drain_out_a_oe)
    else $error("drain active in lockout");
  oper_done_a:
    assert property ($rose(o_operating) |-> $past(i_softstart_done, 3))
    else $error("operating before soft start done");
  sync_duty_a:
    assert property (o_sync_mode |=> !o_duty_control_en)
    else $error("duty control in sync mode");
  sync_loss_a:
    assert property (idle_cnt > SYNC_LOSS_CYC + 16'h000A |-> !o_sync_mode)
    else $error("sync mode kept without clock");
  hard_set_a:
    assert property ((i_hard_trip && i_softstart_dip_deep) [*8] ##1
      (i_hard_trip && i_softstart_dip_deep) [*8] |-> o_hard_short)
    else $error("hard short not flagged");
  discharge_a:
    assert property ($rose(o_softstart_discharge) |->
      $past(o_hard_short, 150))
    else $error("discharge without long hard short");

  cover property (o_sync_mode);
  cover property (o_operating);
  cover property ($rose(o_softstart_discharge));
endmodule

bind ppm_ctrl ppm_ctrl_props #(.HARD_LONG_CYC(HARD_LONG_CYC),
  .SYNC_LOSS_CYC(SYNC_LOSS_CYC)) ppm_ctrl_props_inst (.*);

// File: test/ppm_ext_src.sv
// External sync clock source driving the clock pin.
// Assumes the bench starts it only after the supply is up.
`timescale 1ns/1ns
module ppm_ext_src (
  input  wire i_run,
  output reg  o_ext_clk
);
  // stopped until started
  // 160 ns half period while running, held low when stopped
  initial
  begin
    o_ext_clk = 1'b0;
    forever #160 o_ext_clk = i_run & ~o_ext_clk;
  end
endmodule

// File: test/tb.sv
// Self-checking bench for the protection and mode controller.
// Assumes shortened counts and the external clock source model.
`timescale 1ns/1ns
module tb;
  reg     clk = 1'b0;
  reg     rst = 1'b1;
  reg     en, sup, ovr, ovf, tt, tr, oc, ht, dd, ssd, sse, flt, run, pa, pb;
  wire    ext, a, b, aoe, boe, ssr, dis, pd, duty, spr, sync, op, ovg, thm;
  wire    hs;
  integer n_errors = 0;
  integer samples_checked = 0;
  integer i, sa, sb;

  // Reference clock, 8 ns period
  always #4 clk = ~clk;

  ppm_ctrl #(.HARD_LONG_CYC(16'h00C8), .EN_FILT_CYC(16'h0008),
    .SYNC_LOSS_CYC(16'h0064), .OSC_HALF_CYC(16'h0010)) ppm_ctrl_inst (
    .i_ref_clk(clk), .i_rst(rst), .i_enable_threshold_pin(en),
    .i_supply_lockout_ok(sup), .i_ov_above_rise(ovr),
    .i_ov_above_fall(ovf), .i_temp_above_trip(tt),
    .i_temp_above_release(tr), .i_overcurrent_trip(oc),
    .i_hard_trip(ht), .i_softstart_dip_deep(dd), .i_softstart_done(ssd),
    .i_softstart_empty(sse), .i_ext_clk(ext), .i_ext_clk_floating(flt),
    .o_drain_out_a(a), .o_drain_out_b(b), .o_drain_out_a_oe(aoe),
    .o_drain_out_b_oe(boe), .o_softstart_run(ssr),
    .o_softstart_discharge(dis), .o_enable_pulldown(pd),
    .o_duty_control_en(duty), .o_spread_modulation_en(spr),
    .o_sync_mode(sync), .o_operating(op), .o_overvoltage_guard(ovg),
    .o_thermal_trip(thm), .o_hard_short(hs));

  ppm_ext_src ppm_ext_src_inst (.i_run(run), .o_ext_clk(ext));

  task chk(input got, input exp);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask

  task wt(input integer n);
    repeat (n) @(negedge clk);
  endtask

  // Counts rising edges of each drive over n cycles
  task cnt(input integer n);
  begin
    sa = 0;
    sb = 0;
    for (i = 0; i < n; i = i + 1)
    begin
      pa = a;
      pb = b;
      wt(1);
      sa = sa + (a & ~pa);
      sb = sb + (b & ~pb);
    end
  end
  endtask

  task t_start;
  begin
    sup = 1'b1;
    en = 1'b1;
    wt(4);
    en = 1'b0;
    wt(20);
    chk(ssr | aoe, 1'b0);
    sup = 1'b0;
    en = 1'b1;
    wt(30);
    chk(aoe | boe, 1'b0);
    chk(pd, 1'b1);
    sup = 1'b1;
    wt(10);
    chk(ssr & aoe & boe & ~op, 1'b1);
    ssd = 1'b1;
    wt(10);
    chk(op, 1'b1);
    en = 1'b0;
    wt(4);
    en = 1'b1;
    wt(10);
    chk(op, 1'b1);
    cnt(80);
    chk(sa > 0 && sb > 0, 1'b1);
    oc = 1'b1;
    wt(1);
    oc = 1'b0;
    wt(4);
    chk(a | b, 1'b0);
    wt(6);
    chk(a | b, 1'b0);
    flt = 1'b1;
    wt(5);
    cnt(80);
    chk(sa + sb == 0, 1'b1);
    flt = 1'b0;
  end
  endtask

  task t_sync;
  begin
    run = 1'b1;
    wt(120);
    chk(sync, 1'b0);
    wt(120);
    chk(sync & ~duty & ~spr, 1'b1);
    cnt(240);
    chk(sa >= 2 && sa <= 4, 1'b1);
    run = 1'b0;
    wt(140);
    chk(~sync & duty & spr, 1'b1);
  end
  endtask

  task t_ov;
  begin
    ovr = 1'b1;
    ovf = 1'b1;
    wt(60);
    chk(ovg, 1'b0);
    wt(20);
    chk(ovg & ~a & ~b, 1'b1);
    ovr = 1'b0;
    wt(20);
    chk(ovg, 1'b1);
    ovf = 1'b0;
    wt(10);
    chk(ovg, 1'b0);
  end
  endtask

  task t_temp;
  begin
    tt = 1'b1;
    tr = 1'b1;
    wt(8);
    chk(thm & ~a & ~b, 1'b1);
    tt = 1'b0;
    wt(10);
    chk(thm, 1'b1);
    tr = 1'b0;
    wt(6);
    chk(thm, 1'b0);
  end
  endtask

  task t_hard;
  begin
    dd = 1'b1;
    ht = 1'b1;
    wt(20);
    chk(hs & ~a & ~b, 1'b1);
    wt(200);
    chk(dis, 1'b1);
    ssd = 1'b0;
    ht = 1'b0;
    dd = 1'b0;
    wt(10);
    chk(ssr, 1'b0);
    sse = 1'b1;
    wt(10);
    chk(ssr & ~dis, 1'b1);
    sse = 1'b0;
    // Overcurrent held during soft-start must not blank the drives
    oc = 1'b1;
    cnt(80);
    chk(sa > 0 && sb > 0, 1'b1);
    oc = 1'b0;
    ssd = 1'b1;
    wt(10);
    chk(op, 1'b1);
    // Overcurrent held in operation keeps both drives off
    oc = 1'b1;
    wt(4);
    cnt(40);
    chk(sa + sb == 0, 1'b1);
    oc = 1'b0;
  end
  endtask

  task end_sim;
  begin
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask

  // Main sequence after a six cycle reset
  initial
  begin
    {en, sup, ovr, ovf, tt, tr, oc, ht, dd, ssd, sse, flt, run} = 13'h0000;
    wt(6);
    rst = 1'b0;
    t_start;
    t_sync;
    t_ov;
    t_temp;
    t_hard;
    end_sim;
  end

  // Watchdog at several times the expected run length
  initial
  begin
    #60000;
    n_errors = n_errors + 1;
    end_sim;
  end
endmodule
